//--- abs_reader_pkg.sv
// constants, register map and state type for the absolute position reader
package abs_reader_pkg;
  localparam int CLK_HZ = 20_000_000;
  // controller scan period; every handshake step waits for one scan tick
  localparam int SCAN_TIME_US = 10;
  localparam int SCAN_CYC = (CLK_HZ / 1_000_000) * SCAN_TIME_US;
  localparam int WORD_W = 16;
  localparam int POS_WORDS = 4;
  localparam int A_PAIRS = 19;
  localparam int A_POS_PAIRS = 16;
  localparam int B_BITS = 64;
  localparam int CHK_W = 6;
  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_MASK = 5'h08;
  localparam logic [4:0] OFS_POS0 = 5'h10;
  // control bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_TYPE = 1;
  // sticky status bits, also the interrupt mask layout
  localparam int ST_COMPLETE = 0;
  localparam int ST_DONE_B = 1;
  localparam int ST_ERR_B = 2;
  localparam int ST_FAIL_A = 3;
  // read-only status bits
  localparam int ST_VALID = 8;
  localparam int ST_BUSY = 9;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] STATUS_RST = 4'h0;
  typedef enum logic [2:0] {
    S_IDLE, S_A_REQ, S_A_REL, S_A_HOLD, S_B_REQ, S_B_REL, S_B_HOLD
  } rd_state_e;
endpackage

//--- pos_store.sv
// small word store for the position result, registered read data
`timescale 1ns/1ps
module pos_store #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } store_s;

  store_s q_reg;
  store_s q_next;

  initial begin
    if (DEPTH < 2 || W < 1) $error("pos_store: bad size");
  end

  always_comb begin
    q_next = q_reg;
    if (we) begin
      q_next.mem[waddr] = wdata;
    end
    q_next.rdata = q_reg.mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign rdata = q_reg.rdata;
endmodule // pos_store

//--- absolute_position_reader.sv
// absolute position reader: servo handshake engine with avalon-mm registers
`timescale 1ns/1ps
module absolute_position_reader (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic abs_data0,
  input wire logic abs_data1,
  input wire logic xfer_ready,
  output logic servo_on,
  output logic xfer_mode,
  output logic data_req,
  input wire logic position_ready_line,
  input wire logic position_data_line,
  input wire logic position_wait_line,
  output logic position_enable_line,
  output logic position_request_line
);
  localparam int AW = $clog2(abs_reader_pkg::POS_WORDS);

  typedef struct packed {
    abs_reader_pkg::rd_state_e st;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [1:0] ctrl;
    logic [3:0] mask;
    logic [3:0] status;
    logic valid;
    logic run_q;
    logic [7:0] scan_cnt;
    logic [6:0] cnt;
    logic [15:0] shreg;
    logic [5:0] chk;
    logic [5:0] sum;
    logic rd_ack;
    logic rd_pos;
    logic [31:0] rdata;
  } rd_s;

  rd_s q_reg;
  rd_s q_next;
  logic scan_tick;
  logic run;
  logic d0;
  logic d1;
  logic rdy;
  logic b_rdy;
  logic b_dat;
  logic b_wait;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic bus_wr;
  logic [3:0] ev;

  initial begin
    if (abs_reader_pkg::SCAN_CYC < 1 || abs_reader_pkg::SCAN_CYC > 256) begin
      $error("scan count out of range");
    end
    // counters, shift register and word addressing are sized for these layouts only
    if (abs_reader_pkg::A_POS_PAIRS != abs_reader_pkg::WORD_W) begin
      $error("type one position pairs must fill two words");
    end
    if (abs_reader_pkg::A_PAIRS - abs_reader_pkg::A_POS_PAIRS !=
        abs_reader_pkg::CHK_W / 2) begin
      $error("type one check pairs must carry the check width");
    end
    if (abs_reader_pkg::B_BITS != abs_reader_pkg::POS_WORDS * abs_reader_pkg::WORD_W) begin
      $error("type two bits must fill the result area");
    end
    if (abs_reader_pkg::B_BITS > 127 || abs_reader_pkg::POS_WORDS != 4) begin
      $error("bit counter or store address too narrow");
    end
    if (abs_reader_pkg::WORD_W != 16) begin
      $error("shift register holds one 16-bit word");
    end
  end

  function automatic logic is_pos(input logic [4:0] a);
    is_pos = (a[4:2] >= abs_reader_pkg::OFS_POS0[4:2]);
  endfunction

  // synchronised pin levels, only the second stage is read
  assign d0 = q_reg.sync2[0];
  assign d1 = q_reg.sync2[1];
  assign rdy = q_reg.sync2[2];
  assign b_rdy = q_reg.sync2[3];
  assign b_dat = q_reg.sync2[4];
  assign b_wait = q_reg.sync2[5];
  assign run = q_reg.ctrl[abs_reader_pkg::CTRL_RUN];
  assign scan_tick = (q_reg.scan_cnt == 8'h00);
  assign bus_wr = write & ~read;

  always_comb begin
    q_next = q_reg;
    ev = 4'h0;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = q_reg.shreg;
    q_next.sync1 = {position_wait_line, position_data_line, position_ready_line,
                    xfer_ready, abs_data1, abs_data0};
    q_next.sync2 = q_reg.sync1;
    // steps advance on scan ticks so read time tracks the scan period
    if (scan_tick) begin
      q_next.scan_cnt = 8'(abs_reader_pkg::SCAN_CYC - 1);
    end else begin
      q_next.scan_cnt = q_reg.scan_cnt - 8'h01;
    end
    q_next.run_q = run;

    case (q_reg.st)
      abs_reader_pkg::S_IDLE: begin
        q_next.cnt = 7'h00;
        q_next.sum = 6'h00;
        if (run && !q_reg.run_q) begin
          q_next.valid = 1'b0;
          if (q_reg.ctrl[abs_reader_pkg::CTRL_TYPE]) begin
            q_next.st = abs_reader_pkg::S_B_REQ;
          end else begin
            q_next.st = abs_reader_pkg::S_A_REQ;
          end
        end
      end
      abs_reader_pkg::S_A_REQ: begin
        if (!run) begin
          ev[abs_reader_pkg::ST_FAIL_A] = 1'b1;
          q_next.st = abs_reader_pkg::S_IDLE;
        end else if (scan_tick && rdy) begin
          // sample a bit pair while request is high and ready seen
          q_next.st = abs_reader_pkg::S_A_REL;
          if (q_reg.cnt < 7'(abs_reader_pkg::A_POS_PAIRS)) begin
            q_next.shreg = {d1, d0, q_reg.shreg[15:2]};
            q_next.sum = q_reg.sum + {4'h0, d1, d0};
            if (q_reg.cnt[2:0] == 3'h7) begin
              mem_we = 1'b1; // low word first, then high word
              mem_waddr = AW'(q_reg.cnt[3]);
              mem_wdata = q_next.shreg;
            end
          end else begin
            q_next.chk = {d1, d0, q_reg.chk[5:2]};
          end
        end
      end
      abs_reader_pkg::S_A_REL: begin
        if (!run) begin
          ev[abs_reader_pkg::ST_FAIL_A] = 1'b1;
          q_next.st = abs_reader_pkg::S_IDLE;
        end else if (scan_tick && !rdy) begin
          q_next.cnt = q_reg.cnt + 7'h01;
          if (q_reg.cnt == 7'(abs_reader_pkg::A_PAIRS - 1)) begin
            if (q_reg.chk == q_reg.sum) begin
              q_next.valid = 1'b1;
              ev[abs_reader_pkg::ST_COMPLETE] = 1'b1;
              q_next.st = abs_reader_pkg::S_A_HOLD;
            end else begin
              ev[abs_reader_pkg::ST_FAIL_A] = 1'b1;
              q_next.st = abs_reader_pkg::S_IDLE;
            end
          end else begin
            q_next.st = abs_reader_pkg::S_A_REQ;
          end
        end
      end
      abs_reader_pkg::S_A_HOLD: begin
        if (!run) begin
          q_next.st = abs_reader_pkg::S_IDLE;
        end
      end
      abs_reader_pkg::S_B_REQ: begin
        if (!run || b_wait) begin
          ev[abs_reader_pkg::ST_ERR_B] = 1'b1;
          q_next.st = abs_reader_pkg::S_IDLE;
        end else if (scan_tick && b_rdy) begin
          q_next.st = abs_reader_pkg::S_B_REL;
          q_next.shreg = {b_dat, q_reg.shreg[15:1]};
          if (q_reg.cnt[3:0] == 4'hf) begin
            mem_we = 1'b1; // four words for type two
            mem_waddr = AW'(q_reg.cnt[5:4]);
            mem_wdata = q_next.shreg;
          end
        end
      end
      abs_reader_pkg::S_B_REL: begin
        if (!run || b_wait) begin
          ev[abs_reader_pkg::ST_ERR_B] = 1'b1;
          q_next.st = abs_reader_pkg::S_IDLE;
        end else if (scan_tick && !b_rdy) begin
          q_next.cnt = q_reg.cnt + 7'h01;
          if (q_reg.cnt == 7'(abs_reader_pkg::B_BITS - 1)) begin
            q_next.valid = 1'b1;
            ev[abs_reader_pkg::ST_DONE_B] = 1'b1;
            q_next.st = abs_reader_pkg::S_B_HOLD;
          end else begin
            q_next.st = abs_reader_pkg::S_B_REQ;
          end
        end
      end
      abs_reader_pkg::S_B_HOLD: begin
        if (!run) begin
          q_next.st = abs_reader_pkg::S_IDLE;
        end
      end
      default: begin
        q_next.st = abs_reader_pkg::S_IDLE;
      end
    endcase
    if (ev[abs_reader_pkg::ST_FAIL_A] || ev[abs_reader_pkg::ST_ERR_B]) begin
      q_next.valid = 1'b0;
    end

    // register slave: writes land at once, reads answer one cycle later
    q_next.rd_ack = read & ~q_reg.rd_ack;
    if (read && !q_reg.rd_ack) begin
      q_next.rd_pos = is_pos(address);
      case (address[4:2])
        abs_reader_pkg::OFS_CTRL[4:2]: q_next.rdata = {30'h0, q_reg.ctrl};
        abs_reader_pkg::OFS_STATUS[4:2]: begin
          q_next.rdata = {22'h0, (q_reg.st != abs_reader_pkg::S_IDLE), q_reg.valid,
                          4'h0, q_reg.status};
        end
        abs_reader_pkg::OFS_MASK[4:2]: q_next.rdata = {28'h0, q_reg.mask};
        default: q_next.rdata = 32'h0;
      endcase
    end
    // sticky flags: a new event wins over a write-one clear
    q_next.status = q_reg.status;
    if (bus_wr && byteenable[0] && address[4:2] == abs_reader_pkg::OFS_STATUS[4:2]) begin
      q_next.status = q_reg.status & ~writedata[3:0];
    end
    q_next.status = q_next.status | ev;
    if (bus_wr && byteenable[0]) begin
      if (address[4:2] == abs_reader_pkg::OFS_CTRL[4:2]) begin
        q_next.ctrl = writedata[1:0];
      end
      if (address[4:2] == abs_reader_pkg::OFS_MASK[4:2]) begin
        q_next.mask = writedata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_reg.st <= abs_reader_pkg::S_IDLE;
      q_reg.ctrl <= abs_reader_pkg::CTRL_RST;
      q_reg.mask <= abs_reader_pkg::MASK_RST;
      q_reg.status <= abs_reader_pkg::STATUS_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  pos_store #(
    .W(abs_reader_pkg::WORD_W),
    .DEPTH(abs_reader_pkg::POS_WORDS)
  ) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(address[AW+1:2]),
    .rdata(mem_rdata)
  );

  assign waitrequest = read & ~q_reg.rd_ack;
  // position words stay readable even when invalid; check the valid bit first
  assign readdata = q_reg.rd_pos ? {16'h0, mem_rdata} : q_reg.rdata;
  assign irq = |(q_reg.status & q_reg.mask);
  // output decode from the state register
  assign servo_on = (q_reg.st == abs_reader_pkg::S_A_REQ) ||
                    (q_reg.st == abs_reader_pkg::S_A_REL) ||
                    (q_reg.st == abs_reader_pkg::S_A_HOLD);
  assign xfer_mode = (q_reg.st == abs_reader_pkg::S_A_REQ) ||
                     (q_reg.st == abs_reader_pkg::S_A_REL);
  assign data_req = (q_reg.st == abs_reader_pkg::S_A_REQ);
  assign position_enable_line = (q_reg.st == abs_reader_pkg::S_B_REQ) ||
                                (q_reg.st == abs_reader_pkg::S_B_REL) ||
                                (q_reg.st == abs_reader_pkg::S_B_HOLD);
  assign position_request_line = (q_reg.st == abs_reader_pkg::S_B_REQ);
endmodule // absolute_position_reader

//--- absolute_position_reader_asserts.sv
// concurrent checks on the reader's bus handshake and servo pins
`timescale 1ns/1ps
module absolute_position_reader_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic servo_on,
  input wire logic xfer_mode,
  input wire logic data_req,
  input wire logic xfer_ready,
  input wire logic position_enable_line,
  input wire logic position_request_line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_read_answer;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence s_pair_seen;
    data_req && xfer_ready;
  endsequence
  AST_READ_ONE_WAIT: assert property ($rose(read) |-> s_read_answer)
    else $error("read answer not one cycle after request");
  AST_WRITE_NO_WAIT: assert property (write |-> !waitrequest)
    else $error("write stalled");
  AST_START_BOTH: assert property ($rose(xfer_mode) |-> servo_on && data_req)
    else $error("transfer mode rose without servo-on and request");
  AST_MODE_NEEDS_ON: assert property (xfer_mode |-> servo_on)
    else $error("transfer mode without servo-on");
  AST_REQ_IN_MODE: assert property (data_req |-> xfer_mode)
    else $error("request outside transfer mode");
  // the ready pin passes a two-stage sync, so it must have stood two edges earlier
  AST_REQ_AFTER_READY: assert property ($fell(data_req) && xfer_mode |-> $past(xfer_ready, 2))
    else $error("request released before ready was seen");
  AST_REQ_AFTER_LOW: assert property ($rose(data_req) && $past(xfer_mode) |-> !$past(xfer_ready, 2))
    else $error("next request before ready returned low");
  AST_PAIR_BOUND: assert property (s_pair_seen |-> ##[1:300] !data_req)
    else $error("request not released within one scan");
  AST_ONE_TYPE: assert property (!(servo_on && position_enable_line))
    else $error("both servo signal sets active");
  AST_B_REQ_ENABLED: assert property (position_request_line |-> position_enable_line)
    else $error("type two request without enable");
endmodule // absolute_position_reader_asserts
bind absolute_position_reader absolute_position_reader_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .read(read), .write(write), .waitrequest(waitrequest), .servo_on(servo_on),
  .xfer_mode(xfer_mode), .data_req(data_req), .xfer_ready(xfer_ready),
  .position_enable_line(position_enable_line), .position_request_line(position_request_line));

//--- servo_model.sv
// servo at the far side: type one pair handshake and type two bit handshake
`timescale 1ns/1ps
module servo_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] pos,
  input wire logic bad_chk,
  input wire logic xfer_mode,
  input wire logic data_req,
  input wire logic position_enable_line,
  input wire logic position_request_line,
  output logic abs_data0,
  output logic abs_data1,
  output logic xfer_ready,
  output logic position_ready_line,
  output logic position_data_line
);
  logic [5:0] chk;
  logic [4:0] k;
  logic [5:0] j;
  logic [37:0] frame;
  logic [63:0] frame_b;
  always_comb begin
    chk = 6'h00;
    for (int i = 0; i < 16; i++) chk = chk + 6'(pos[2*i+:2]);
  end
  // bad_chk flips one check bit so the device must refuse the frame
  assign frame = {chk ^ {5'h00, bad_chk}, pos};
  // type two sends the position and then its inverse, so each upper word differs from the word two places below it
  assign frame_b = {~pos, pos};
  always @(posedge clk) begin
    if (!rst_n) begin
      {abs_data1, abs_data0} <= 2'b00;
      xfer_ready <= 1'b0;
      k <= 5'h00;
    end else if (!xfer_mode) begin
      xfer_ready <= 1'b0;
      k <= 5'h00;
    end else if (data_req && !xfer_ready) begin
      {abs_data1, abs_data0} <= frame[2*k+:2];
      xfer_ready <= 1'b1;
    end else if (!data_req && xfer_ready) begin
      // released lines carry junk, never the last pair
      {abs_data1, abs_data0} <= ~{abs_data1, abs_data0};
      xfer_ready <= 1'b0;
      k <= k + 5'h01;
    end
  end
  always @(posedge clk) begin
    if (!rst_n || !position_enable_line) begin
      position_ready_line <= 1'b0;
      position_data_line <= 1'b0;
      j <= 6'h00;
    end else if (position_request_line && !position_ready_line) begin
      position_data_line <= frame_b[j];
      position_ready_line <= 1'b1;
    end else if (!position_request_line && position_ready_line) begin
      // released data line carries junk, never the last bit
      position_data_line <= ~position_data_line;
      position_ready_line <= 1'b0;
      j <= j + 6'h01;
    end
  end
endmodule // servo_model

//--- test_absolute_position_reader.sv
// self-checking bench for the absolute position reader
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_absolute_position_reader;
  logic clk, rst_n, read, write, irq, waitrequest;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rd, pos;
  logic [3:0] byteenable;
  logic abs_data0, abs_data1, xfer_ready, servo_on, xfer_mode, data_req, bad_chk;
  logic b_rdy, b_dat, b_wait, b_en, b_req;
  int err_count, n_compared, i;
  absolute_position_reader dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .abs_data0(abs_data0), .abs_data1(abs_data1),
    .xfer_ready(xfer_ready), .servo_on(servo_on), .xfer_mode(xfer_mode), .data_req(data_req),
    .position_ready_line(b_rdy), .position_data_line(b_dat), .position_wait_line(b_wait),
    .position_enable_line(b_en), .position_request_line(b_req));
  servo_model servo (.clk(clk), .rst_n(rst_n), .pos(pos), .bad_chk(bad_chk),
    .xfer_mode(xfer_mode), .data_req(data_req), .abs_data0(abs_data0),
    .abs_data1(abs_data1), .xfer_ready(xfer_ready), .position_enable_line(b_en),
    .position_request_line(b_req), .position_ready_line(b_rdy), .position_data_line(b_dat));
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // request held until the rising edge that sees waitrequest low; an edge passes between calls
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
  // supervisor gives up well after the longest read, a type two read
  task automatic wait_irq();
    for (int n = 0; n < 40000 && irq !== 1'b1; n++) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #4000000;
    err_count++;
    end_sim();
  end
  initial begin
    {rst_n, read, write, bad_chk, b_wait} = 5'h00;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    pos = 32'h89ab_c5e3;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus_wr(5'h0c, 32'hffff_ffff);
    byteenable <= 4'he;
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h1);
    byteenable <= 4'hf;
    for (i = 0; i < 4; i++) begin
      bus_rd(5'(i * 4), rd);
      `CHK(rd, 32'h0)
    end
    $display("reset values done");
    bus_wr(abs_reader_pkg::OFS_MASK, 32'h1);
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    `CHK({servo_on, xfer_mode, data_req, b_en}, 4'b1110)
    wait_irq();
    bus_rd(abs_reader_pkg::OFS_STATUS, rd);
    `CHK(rd[8:0], 9'h101)
    `CHK({servo_on, xfer_mode}, 2'b10)
    bus_rd(abs_reader_pkg::OFS_POS0, rd);
    `CHK(rd[15:0], pos[15:0])
    bus_rd(abs_reader_pkg::OFS_POS0 + 5'h04, rd);
    `CHK(rd[15:0], pos[31:16])
    bus_wr(abs_reader_pkg::OFS_STATUS, 32'h1);
    bus_rd(abs_reader_pkg::OFS_STATUS, rd);
    `CHK({irq, rd[3:0]}, 5'h00)
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h0);
    repeat (2) @(negedge clk);
    `CHK(servo_on, 1'b0)
    $display("type one read done");
    bad_chk <= 1'b1;
    bus_wr(abs_reader_pkg::OFS_MASK, 32'h8);
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h1);
    wait_irq();
    bus_rd(abs_reader_pkg::OFS_STATUS, rd);
    `CHK({rd[9:0], xfer_mode}, 11'h010)
    bus_wr(abs_reader_pkg::OFS_STATUS, 32'h8);
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h0);
    bad_chk <= 1'b0;
    $display("check mismatch done");
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h1);
    repeat (3000) @(posedge clk);
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h0);
    wait_irq();
    bus_rd(abs_reader_pkg::OFS_STATUS, rd);
    `CHK({rd[9:0], servo_on}, 11'h010)
    bus_wr(abs_reader_pkg::OFS_STATUS, 32'h8);
    $display("abort done");
    bus_wr(abs_reader_pkg::OFS_MASK, 32'h4);
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h3);
    repeat (2) @(negedge clk);
    `CHK({b_en, b_req, servo_on, xfer_mode}, 4'b1100)
    @(posedge clk);
    b_wait <= 1'b1;
    wait_irq();
    bus_rd(abs_reader_pkg::OFS_STATUS, rd);
    `CHK(rd[3:0], 4'h4)
    bus_wr(abs_reader_pkg::OFS_STATUS, 32'h4);
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h0);
    $display("type two error done");
    b_wait <= 1'b0;
    bus_wr(abs_reader_pkg::OFS_MASK, 32'h2);
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h3);
    wait_irq();
    bus_rd(abs_reader_pkg::OFS_STATUS, rd);
    `CHK(rd[9:0], 10'h302)
    `CHK({b_en, b_req}, 2'b10)
    for (i = 0; i < 4; i++) begin
      bus_rd(abs_reader_pkg::OFS_POS0 + 5'(i * 4), rd);
      `CHK(rd, {16'h0, 16'({~pos, pos} >> (16 * i))})
    end
    bus_wr(abs_reader_pkg::OFS_STATUS, 32'h2);
    bus_wr(abs_reader_pkg::OFS_CTRL, 32'h0);
    repeat (2) @(negedge clk);
    `CHK({irq, b_en}, 2'b00)
    $display("type two read done");
    end_sim();
  end
endmodule // test_absolute_position_reader
